// ---- verilog/dvp_pkg.sv ----
// constants, register map and codes for the drive parameter bank
//-----------------------------------------------------------------
// What this block does
// - option A error: 0 trips, 1 continues
// - option B error: 0 trips, 1 continues
// - alternate P gain accepts 0 to 10000
// - alternate I gain accepts 0 to 10000
// - alternate pure P gain accepts 0 to 1000
// - startup boost accepts 0 to 50
// - loop mode codes speed, position, second, high-accuracy
// - pulse input mode accepts codes 0 to 2
// - orient speed from start frequency to 12000
// - position ready window accepts 0 to 10000
// - position ready delay accepts 0 to 999
// - gear side: 0 feedback, 1 command
// - electronic gear num and den 1 to 9999
// - feedforward gain spans full 16 bits
// - rotor compensation: 0 off, 1 on
// - overspeed threshold accepts 0 to 1500
// - speed deviation threshold accepts 0 to 12000
// - motor gear num and den 1 to 9999
// - ramp source: panel, option A, option B
// - orient position source: panel, option A, option B
//-----------------------------------------------------------------
package dvp_pkg;

  // -------------------------------------------------------------
  // register numbers, reset values and pairing
  // -------------------------------------------------------------
  localparam int NUM_REGS = 38;             // stored parameters
  localparam logic [15:0] REG_NUM [NUM_REGS] = '{
    16'h1528, 16'h1529, 16'h152a, 16'h152b, 16'h152c, 16'h152d,
    16'h153d, 16'h153e, 16'h153f, 16'h1547, 16'h1548, 16'h1551,
    16'h1552, 16'h1553, 16'h1554, 16'h1601, 16'h1602, 16'h160b,
    16'h160c, 16'h160d, 16'h160e, 16'h160f, 16'h1610, 16'h1611,
    16'h1612, 16'h1613, 16'h1614, 16'h1615, 16'h1616, 16'h1617,
    16'h1618, 16'h1619, 16'h161a, 16'h161b, 16'h161c, 16'h161d,
    16'h161f, 16'h1620};
  // reset holds the least legal value of each parameter, but zero for the signed bias and for orient speed whatever ORIENT_MIN
  localparam logic [15:0] REG_RST [NUM_REGS] = '{
    16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0001,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0080,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
    16'h0000, 16'h0000};
  localparam int FIRST_LO = 1;              // upper words sit at 0,2,4
  localparam int LAST_LO  = 5;              // lower words sit at 1,3,5

  // indices of parameters that steer outputs, plus the gear numerator and the signed bias
  localparam int IDX_OPT_A   = 15;
  localparam int IDX_OPT_B   = 16;
  localparam int IDX_MODE    = 18;
  localparam int IDX_PULSE   = 19;
  localparam int IDX_SIDE    = 25;
  localparam int IDX_EGEAR_N = 26;
  localparam int IDX_BIAS    = 30;          // the only signed one
  localparam int IDX_RRC     = 31;
  localparam int IDX_RAMP    = 36;
  localparam int IDX_OPOS    = 37;

  // status registers of this block
  localparam logic [15:0] STAT_NUM    = 16'h16f0;
  localparam logic [15:0] REJ_CNT_NUM = 16'h16f1;
  localparam int          STAT_REJ_BIT = 0;

  // -------------------------------------------------------------
  // codes
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SPEED = 2'h0, MODE_POS = 2'h1, MODE_POS2 = 2'h2,
    MODE_HIGH_ACCURACY_POSITION_REGULATION  = 2'h3                       // high-accuracy position
  } dvp_loop_mode_t;
  typedef enum logic [1:0] {
    SRC_PANEL = 2'h0, SRC_OPT_A = 2'h1, SRC_OPT_B = 2'h2
  } dvp_source_t;
  typedef enum logic {
    ERR_TRIP = 1'h0, ERR_CONTINUE = 1'h1
  } dvp_err_action_t;

endpackage : dvp_pkg

// ---- verilog/dvp_param_regs.sv ----
// drive parameter register bank with range-checked writes
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module dvp_param_regs
  import dvp_pkg::*;
#(
  parameter logic [15:0] ORIENT_MIN = 16'h0000  // starting frequency
) (
  input  wire logic        clk_sys_i,       // 40 MHz system clock
  input  wire logic        rst_i,           // async reset, high
  input  wire logic [15:0] addr_i,          // register number
  input  wire logic [15:0] wdata_i,         // write data
  input  wire logic        wr_i,            // write strobe
  input  wire logic        rd_i,            // read strobe
  output logic      [15:0] rdata_o,         // read data, next cycle
  output logic             opt_a_continue_o, // option A error action
  output logic             opt_b_continue_o, // option B error action
  output logic      [1:0]  closed_loop_mode_o, // loop mode code
  output logic      [1:0]  pulse_input_mode_o, // pulse train mode
  output logic             egear_cmd_side_o, // gear on command side
  output logic             rotor_res_comp_enable_o, // compensation
  output logic      [1:0]  ramp_time_source_o, // ramp time source
  output logic      [1:0]  orient_pos_source_o, // stop pos source
  output logic             write_rejected_o  // sticky reject flag
);

  // -------------------------------------------------------------
  // limits: {least, most} as signed 32-bit, one line per register
  // -------------------------------------------------------------
  // pairs carry the joined limit on the upper word; lower-word
  // entries are never consulted
  localparam logic [63:0] LIMITS [NUM_REGS] = '{
    {32'h0000_0001, 32'h0000_fffa},   // inductance pair
    {32'h0000_0000, 32'h0000_0000},   // lower word
    {32'h0000_0001, 32'h0000_fffa},   // no-load current pair
    {32'h0000_0000, 32'h0000_0000},   // lower word
    {32'h0000_0001, 32'h0098_9298},   // inertia pair
    {32'h0000_0000, 32'h0000_0000},   // lower word
    {32'h0000_0000, 32'h0000_2710},   // speed loop P gain
    {32'h0000_0000, 32'h0000_2710},   // speed loop I gain
    {32'h0000_0000, 32'h0000_03e8},   // pure P gain
    {32'h0000_0000, 32'h0000_03e8},   // zero-hertz limit
    {32'h0000_0000, 32'h0000_0032},
    {32'h0000_0000, 32'h0000_2710},
    {32'h0000_0000, 32'h0000_2710},
    {32'h0000_0000, 32'h0000_03e8},
    {32'h0000_0000, 32'h0000_270f},   // gain switch time
    {32'h0000_0000, 32'(ERR_CONTINUE)},
    {32'h0000_0000, 32'(ERR_CONTINUE)},
    {32'h0000_0080, 32'h0000_ffff},   // encoder pulses
    {32'h0000_0000, 32'(MODE_HIGH_ACCURACY_POSITION_REGULATION)},
    {32'h0000_0000, 32'h0000_0002},
    {32'h0000_0000, 32'h0000_0fff},   // orient stop position
    {32'(ORIENT_MIN), 32'h0000_2ee0},
    {32'h0000_0000, 32'h0000_0001},   // orient direction
    {32'h0000_0000, 32'h0000_2710},
    {32'h0000_0000, 32'h0000_03e7},
    {32'h0000_0000, 32'h0000_0001},
    {32'h0000_0001, 32'h0000_270f},
    {32'h0000_0001, 32'h0000_270f},
    {32'h0000_0000, 32'h0000_ffff},
    {32'h0000_0000, 32'h0000_2710},   // position loop gain
    {32'hffff_f800, 32'h0000_0800},   // position bias, signed
    {32'h0000_0000, 32'h0000_0001},
    {32'h0000_0000, 32'h0000_05dc},
    {32'h0000_0000, 32'h0000_2ee0},
    {32'h0000_0001, 32'h0000_270f},
    {32'h0000_0001, 32'h0000_270f},
    {32'h0000_0000, 32'(SRC_OPT_B)},
    {32'h0000_0000, 32'(SRC_OPT_B)}
  };

  // -------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------
  // register number to index, -1 when unused
  function automatic int find_idx(input logic [15:0] num);
    int r;
    r = -1;
    for (int k = 0; k < NUM_REGS; k++) begin
      if (REG_NUM[k] == num) begin
        r = k;
      end
    end
    return r;
  endfunction : find_idx

  // lower word of a pair: odd index within the pair range
  function automatic logic is_lo(input int k);
    return (k >= FIRST_LO) && (k <= LAST_LO) && k[0];
  endfunction : is_lo

  // upper word of a pair
  function automatic logic is_hi(input int k);
    return (k < LAST_LO) && !k[0];
  endfunction : is_hi

  // value as the range check sees it
  function automatic logic signed [31:0] widen(
    input int k, input logic [15:0] hi, input logic [15:0] lo);
    if (is_hi(k)) begin
      return {hi, lo};
    end else if (k == IDX_BIAS) begin
      return {{16{lo[15]}}, lo};
    end else begin
      return {16'h0000, lo};
    end
  endfunction : widen

  // signed comparison against both limits
  function automatic logic lim_ok(
    input int k, input logic signed [31:0] v);
    logic signed [31:0] lo_lim;
    logic signed [31:0] hi_lim;
    lo_lim = LIMITS[k][63:32];
    hi_lim = LIMITS[k][31:0];
    return (v >= lo_lim) && (v <= hi_lim);
  endfunction : lim_ok

  // -------------------------------------------------------------
  // storage and decode signals
  // -------------------------------------------------------------
  logic [15:0] param_q [NUM_REGS];  // parameter flops
  int          wr_idx;              // decoded index of addr_i
  int          base_idx;            // range-check owner of a pair
  logic        wr_hit;              // addr_i is a parameter
  logic        wr_ok;               // candidate value in range
  logic [15:0] cand_hi;             // upper word as if written
  logic [15:0] cand_lo;             // lower word as if written
  logic        rej_now;             // write refused this cycle
  logic        clr_now;             // software clears the flag
  logic [15:0] rej_cnt;             // refused writes, saturating
  logic [15:0] next_rdata;          // read mux output

  // -------------------------------------------------------------
  // write decode and range check
  // -------------------------------------------------------------
  // a half of a pair is judged together with the stored other
  // half, so the joined value can never leave its range
  always_comb begin
    wr_idx   = find_idx(addr_i);
    wr_hit   = (wr_idx >= 0);
    base_idx = wr_idx;
    cand_hi  = 16'h0000;
    cand_lo  = wdata_i;
    if (wr_hit && is_hi(wr_idx)) begin
      cand_hi = wdata_i;
      cand_lo = param_q[wr_idx + 1];
    end else if (wr_hit && is_lo(wr_idx)) begin
      base_idx = wr_idx - 1;
      cand_hi  = param_q[wr_idx - 1];
    end
    wr_ok = wr_hit && lim_ok(base_idx,
                             widen(base_idx, cand_hi, cand_lo));
  end

  assign rej_now = wr_i && wr_hit && !wr_ok;
  assign clr_now = wr_i && (addr_i == STAT_NUM)
                   && wdata_i[STAT_REJ_BIT];

  // -------------------------------------------------------------
  // parameter storage
  // -------------------------------------------------------------
  // only in-range writes land; others leave the old value
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < NUM_REGS; k++) begin
        param_q[k] <= REG_RST[k];
      end
    end else if (wr_i && wr_ok) begin
      param_q[wr_idx] <= wdata_i;
    end
  end

  // -------------------------------------------------------------
  // reject flag and counter
  // -------------------------------------------------------------
  // set beats clear so a refusal in the clearing cycle survives
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      write_rejected_o <= 1'b0;
    end else if (rej_now) begin
      write_rejected_o <= 1'b1;
    end else if (clr_now) begin
      write_rejected_o <= 1'b0;
    end
  end

  // counter stops at all ones rather than wrapping to zero
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rej_cnt <= 16'h0000;
    end else if (rej_now && (rej_cnt != 16'hffff)) begin
      rej_cnt <= rej_cnt + 16'h0001;
    end
  end

  // -------------------------------------------------------------
  // read path
  // -------------------------------------------------------------
  // data appear one cycle after the strobe and only then
  always_comb begin
    next_rdata = 16'h0000;
    if (!rd_i) begin
      next_rdata = 16'h0000;
    end else if (wr_hit) begin
      next_rdata = param_q[wr_idx];
    end else if (addr_i == STAT_NUM) begin
      next_rdata = {15'h0000, write_rejected_o};
    end else if (addr_i == REJ_CNT_NUM) begin
      next_rdata = rej_cnt;
    end else begin
      next_rdata = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // -------------------------------------------------------------
  // settings driven to the control logic
  // -------------------------------------------------------------
  // taken straight from the storage flops
  assign opt_a_continue_o        = param_q[IDX_OPT_A][0];
  assign opt_b_continue_o        = param_q[IDX_OPT_B][0];
  assign closed_loop_mode_o      = param_q[IDX_MODE][1:0];
  assign pulse_input_mode_o      = param_q[IDX_PULSE][1:0];
  assign egear_cmd_side_o        = param_q[IDX_SIDE][0];
  assign rotor_res_comp_enable_o = param_q[IDX_RRC][0];
  assign ramp_time_source_o      = param_q[IDX_RAMP][1:0];
  assign orient_pos_source_o     = param_q[IDX_OPOS][1:0];

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // helper: what a refused write would have overwritten
  int          rej_idx;
  logic [15:0] rej_old;
  logic        rej_seen;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rej_idx  <= 0;
      rej_old  <= 16'h0000;
      rej_seen <= 1'b0;
    end else begin
      rej_idx  <= (wr_idx < 0) ? 0 : wr_idx;
      rej_old  <= param_q[(wr_idx < 0) ? 0 : wr_idx];
      rej_seen <= rej_now;
    end
  end

  sequence s_unmapped_rd;
    rd_i && !wr_hit && (addr_i != STAT_NUM)
         && (addr_i != REJ_CNT_NUM);
  endsequence

  sequence s_mode_wr;
    wr_i && (addr_i == REG_NUM[IDX_MODE])
         && (wdata_i <= 16'(MODE_HIGH_ACCURACY_POSITION_REGULATION));
  endsequence

  sequence s_gear_zero;
    wr_i && (addr_i == REG_NUM[IDX_EGEAR_N]) && (wdata_i == 16'h0)
    ##1 rd_i && (addr_i == REG_NUM[IDX_EGEAR_N]);
  endsequence

  read_one_cycle_a: assert property (
    !$past(rd_i) |-> (rdata_o == 16'h0000))
    else $error("read data outside the answer cycle");

  unmapped_read_a: assert property (
    s_unmapped_rd |=> (rdata_o == 16'h0000))
    else $error("unused register read not zero");

  reject_hold_a: assert property (
    rej_seen |-> (param_q[rej_idx] == rej_old))
    else $error("refused write changed the register");

  accept_store_a: assert property (
    wr_i && wr_ok |=> (param_q[$past(wr_idx)] == $past(wdata_i)))
    else $error("in-range write not stored");

  for (genvar k = 0; k < NUM_REGS; k++) begin : g_rng
    if (!(k >= FIRST_LO && k <= LAST_LO && k % 2 == 1)) begin : g_c
      range_held_a: assert property (
        lim_ok(k, widen(k, param_q[k],
                        param_q[(k < LAST_LO) ? k + 1 : k])))
        else $error("stored value outside its range");
    end
  end

  pair_join_a: assert property (
    wr_i && wr_ok && is_hi(wr_idx)
    |=> (param_q[$past(wr_idx) + 1] == $past(cand_lo)))
    else $error("upper word write disturbed the lower word");

  mode_follow_a: assert property (
    s_mode_wr |=> (closed_loop_mode_o == $past(wdata_i[1:0]))
                  ##1 $stable(closed_loop_mode_o) || $past(wr_i))
    else $error("loop mode output did not follow the write");

  opt_a_hold_a: assert property (
    wr_i && (addr_i == REG_NUM[IDX_OPT_A]) && (wdata_i > 16'h1)
    |=> $stable(opt_a_continue_o) && write_rejected_o)
    else $error("option A action took an illegal code");

  opt_b_hold_a: assert property (
    wr_i && (addr_i == REG_NUM[IDX_OPT_B]) && (wdata_i > 16'h1)
    |=> $stable(opt_b_continue_o) && write_rejected_o)
    else $error("option B action took an illegal code");

  gear_zero_a: assert property (
    s_gear_zero |=> (rdata_o != 16'h0000))
    else $error("gear numerator accepted zero");

  // a refusal and a clear can never share one bus cycle, so the
  // set path and the clear path are guarded one by one
  flag_set_wins_a: assert property (
    rej_now |=> write_rejected_o)
    else $error("reject flag not set by a refused write");

  flag_clear_a: assert property (
    clr_now && !rej_now |=> !write_rejected_o)
    else $error("reject flag not cleared by software");

endmodule : dvp_param_regs

// ---- verif/test_drive_vector_param_regs.sv ----
// self-checking bench for the drive parameter register bank
`timescale 1ns/100ps
module test_drive_vector_param_regs
  import dvp_pkg::*;
;
  // ---------------------------------------------------------------
  // design signals
  // ---------------------------------------------------------------
  logic        clk_sys_i;         // 40 MHz clock
  logic        rst_i;             // async reset, high
  logic [15:0] addr_i;            // register number
  logic [15:0] wdata_i;           // write data
  logic        wr_i;              // write strobe
  logic        rd_i;              // read strobe
  logic [15:0] rdata_o;           // read data
  logic        opt_a_continue_o;  // option a action
  logic        opt_b_continue_o;  // option b action
  logic [1:0]  closed_loop_mode_o; // loop mode
  logic [1:0]  pulse_input_mode_o; // pulse mode
  logic        egear_cmd_side_o;  // gear side
  logic        rotor_res_comp_enable_o; // compensation
  logic [1:0]  ramp_time_source_o; // ramp source
  logic [1:0]  orient_pos_source_o; // stop position source
  logic        write_rejected_o;  // sticky reject flag
  // ---------------------------------------------------------------
  // reference model: legal range per parameter, pairs as joined value
  // ---------------------------------------------------------------
  int lo_t [NUM_REGS] = '{1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0,
    0, 0, 0, 0, 0, 128, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 0,
    -2048, 0, 0, 0, 1, 1, 0, 0};
  int hi_t [NUM_REGS] = '{65530, 65530, 65530, 65530, 9999000,
    9999000, 10000, 10000, 1000, 1000, 50, 10000, 10000, 1000,
    9999, 1, 1, 65535, 3, 2, 4095, 12000, 1, 10000, 999, 1, 9999,
    9999, 65535, 10000, 2048, 1, 1500, 12000, 9999, 9999, 2, 2};
  logic [15:0] unused_t [4] = '{16'h152e, 16'h1555, 16'h161e,
    16'h1603};                    // numbers with nothing behind them
  logic [15:0] mdl [NUM_REGS];    // expected stored values
  logic        rej_flag;          // expected sticky flag
  logic [15:0] rej_cnt;           // expected reject count
  logic [31:0] lfsr_state = 32'h2a0570aa; // fixed seed
  logic [31:0] r;                 // current random word
  logic [15:0] v;                 // value to write
  logic [15:0] d;                 // value read back
  int          k;                 // parameter index
  int          span;              // legal span width
  int          err_count = 0;     // mismatches
  int          total_checks = 0;  // comparisons made
  int          vals [4];          // boundary candidates

  dvp_param_regs #(.ORIENT_MIN(16'h0000)) uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .opt_a_continue_o(opt_a_continue_o),
    .opt_b_continue_o(opt_b_continue_o),
    .closed_loop_mode_o(closed_loop_mode_o),
    .pulse_input_mode_o(pulse_input_mode_o),
    .egear_cmd_side_o(egear_cmd_side_o),
    .rotor_res_comp_enable_o(rotor_res_comp_enable_o),
    .ramp_time_source_o(ramp_time_source_o),
    .orient_pos_source_o(orient_pos_source_o),
    .write_rejected_o(write_rejected_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] next_rand();
    lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h80200003)};
    return lfsr_state;
  endfunction : next_rand

  // pair halves are judged on the joined value with the stored mate
  function automatic bit legal(input int i, input logic [15:0] x);
    longint j;
    if (i < 6) begin
      j = (i % 2 == 0) ? {x, mdl[i+1]} : {mdl[i-1], x};
    end else if (i == IDX_BIAS) begin
      j = $signed(x);
    end else begin
      j = x;
    end
    return (j >= lo_t[i]) && (j <= hi_t[i]);
  endfunction : legal

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus_wr(input logic [15:0] a, input logic [15:0] x);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= x;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask : bus_wr

  // data stand only in the cycle after the strobe, then fall to zero
  task automatic bus_rd(input logic [15:0] a, output logic [15:0] x);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 x = rdata_o;
    @(posedge clk_sys_i);
    #1 chk("idle read data", 16'h0000, rdata_o);
  endtask : bus_rd

  // write strobe followed at once by a read strobe, no idle cycle
  task automatic bus_wr_rd(input logic [15:0] a,
                           input logic [15:0] x,
                           output logic [15:0] y);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= x;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
    rd_i    <= 1'b1;
    @(posedge clk_sys_i);
    rd_i    <= 1'b0;
    #1 y = rdata_o;
  endtask : bus_wr_rd

  // expected effect of a write on the stored values and the flag
  task automatic mdl_wr(input int i, input logic [15:0] x);
    if (legal(i, x)) begin
      mdl[i] = x;
    end else begin
      rej_flag = 1'b1;
      if (rej_cnt != 16'hffff) rej_cnt = rej_cnt + 16'h0001;
    end
  endtask : mdl_wr

  task automatic do_wr(input int i, input logic [15:0] x);
    mdl_wr(i, x);
    bus_wr(REG_NUM[i], x);
  endtask : do_wr

  task automatic chk_reg(input int i);
    bus_rd(REG_NUM[i], d);
    chk($sformatf("reg %h", REG_NUM[i]), mdl[i], d);
  endtask : chk_reg

  task automatic chk_outs();
    chk("opt a", 16'(mdl[IDX_OPT_A][0]), 16'(opt_a_continue_o));
    chk("opt b", 16'(mdl[IDX_OPT_B][0]), 16'(opt_b_continue_o));
    chk("mode", 16'(mdl[IDX_MODE][1:0]), 16'(closed_loop_mode_o));
    chk("pulse", 16'(mdl[IDX_PULSE][1:0]), 16'(pulse_input_mode_o));
    chk("side", 16'(mdl[IDX_SIDE][0]), 16'(egear_cmd_side_o));
    chk("rrc", 16'(mdl[IDX_RRC][0]), 16'(rotor_res_comp_enable_o));
    chk("ramp", 16'(mdl[IDX_RAMP][1:0]), 16'(ramp_time_source_o));
    chk("opos", 16'(mdl[IDX_OPOS][1:0]), 16'(orient_pos_source_o));
    chk("reject flag", 16'(rej_flag), 16'(write_rejected_o));
  endtask : chk_outs

  task automatic do_reset();
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) mdl[i] = REG_RST[i];
    rej_flag = 1'b0;
    rej_cnt  = 16'h0000;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1 chk_outs();
  endtask : do_reset

  // ---------------------------------------------------------------
  // hang guard
  // ---------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    err_count++;
    $display("unexpected run length: expected end seen none");
    complete_run();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    addr_i = 16'h0000;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    do_reset();
    // reset values and every boundary, one beyond each edge included
    for (k = 0; k < NUM_REGS; k++) begin
      chk_reg(k);
      vals = '{lo_t[k] - 1, hi_t[k] + 1, hi_t[k], lo_t[k]};
      for (int j = 0; j < 4; j++) begin
        do_wr(k, 16'(vals[j]));
        chk_reg(k);
      end
      chk_outs();
    end
    // every code of the selectors; code 3, one beyond the last of pulse, ramp and orient source, is refused, all four mode codes land
    for (int c = 0; c < 4; c++) begin
      do_wr(IDX_MODE, 16'(c));
      do_wr(IDX_PULSE, 16'(c));
      do_wr(IDX_RAMP, 16'(c));
      do_wr(IDX_OPOS, 16'(c));
      @(posedge clk_sys_i);
      #1 chk_outs();
    end
    // wide value: upper word first, then lower words 1024 and 1025 past the top are refused
    do_wr(4, 16'h0098);
    do_wr(5, 16'h9698);
    do_wr(5, 16'h9699);
    chk_reg(4);
    chk_reg(5);
    // random traffic with unused numbers among it
    repeat (400) begin
      r = next_rand();
      k = int'(r[31:16]) % NUM_REGS;
      span = hi_t[k] - lo_t[k] + 1;
      case (r[2:0])
        3'h0: v = 16'(lo_t[k] - 1);
        3'h1: v = 16'(hi_t[k] + 1);
        3'h2: v = r[15:0];
        default: v = 16'(lo_t[k] + int'(r[15:4]) % span);
      endcase
      do_wr(k, v);
      chk_reg(k);
      chk_outs();
      if (r[5:3] == 3'h0) begin
        bus_wr(unused_t[r[7:6]], r[31:16]);
        bus_rd(unused_t[r[7:6]], d);
        chk("unused number", 16'h0000, d);
      end
    end
    // back to back: write then read with no idle cycle between
    for (int j = 0; j < 2; j++) begin
      v = 16'(j * 7);               // zero is refused, seven lands
      mdl_wr(IDX_EGEAR_N, v);
      bus_wr_rd(REG_NUM[IDX_EGEAR_N], v, d);
      chk("gear back to back", mdl[IDX_EGEAR_N], d);
    end
    // status flag and count, then clearing the flag
    bus_rd(STAT_NUM, d);
    chk("status", 16'(rej_flag), d);
    bus_rd(REJ_CNT_NUM, d);
    chk("reject count", rej_cnt, d);
    bus_wr(STAT_NUM, 16'h0001);
    rej_flag = 1'b0;
    @(posedge clk_sys_i);
    #1 chk_outs();
    // reset in mid-run restores every value
    do_reset();
    for (k = 0; k < NUM_REGS; k++) chk_reg(k);
    complete_run();
  end
endmodule : test_drive_vector_param_regs
